// [rtl/exec_core.sv]
`timescale 1ns/100ps
module exec_core (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic cmd_valid_in,
  input exec_pkg::cmd_s cmd_in,
  input exec_pkg::opr_s opr_in,
  input exec_pkg::flags_s flags_in,
  input wire logic system_mode_in,
  input wire logic external_unit_present_bit_in,
  input wire logic irq_pending_in,
  input wire logic bus_ack_in,
  input wire logic [15:0] bus_rdata_in,
  output logic cmd_ready_out,
  output logic bus_req_out,
  output exec_pkg::bus_s bus_out,
  output logic done_out,
  output logic suspend_out,
  output logic trap_priv_out,
  output logic trap_ext_out,
  output logic ext_start_out,
  output logic ctrl_exec_out,
  output exec_pkg::amode_e ext_amode_out,
  output exec_pkg::flags_s flags_out,
  output logic [31:0] result_out,
  output logic [31:0] save_pc_out,
  output logic [31:0] src_out,
  output logic [31:0] dst_out,
  output logic [15:0] cnt_out
);
  import exec_pkg::*;

  function automatic logic [31:0] step_ptr(input logic [31:0] p,
    input logic [15:0] d, input logic down);
    step_ptr = {p[31:16], down ? p[15:0] - d : p[15:0] + d};
  endfunction

  state_e state_r;
  state_e state_nxt;
  cmd_s cmd_r;
  logic [31:0] data_r;
  logic [15:0] port_r;
  logic [31:0] src_r;
  logic [31:0] dst_r;
  logic [15:0] cnt_r;
  logic [1:0] step_r;
  logic [1:0] step_nxt;
  logic [15:0] tmp_r;
  logic [3:0] itc_r;
  logic hit_r;
  logic cmpc_r;
  logic cmps_r;
  logic priv_trap;
  logic ext_trap;
  logic ext_go;
  logic [31:0] sh_res;
  logic [3:0] sh_czsv;
  flags_s acc_flags;
  flags_s blk_flags;

  shift_unit u_shift (
    .val_in(opr_in.data),
    .size_in(cmd_in.size),
    .shop_in(cmd_in.shop),
    .dyn_in(cmd_in.dyn_amt),
    .imm_amt_in(cmd_in.imm_amt),
    .reg_amt_in(opr_in.amt),
    .two_in(cmd_in.two),
    .cin_in(flags_in.c),
    .res_out(sh_res),
    .czsv_out(sh_czsv)
  );

  op_screen u_screen (
    .opcode_in(cmd_in.opcode),
    .kind_in(cmd_in.kind),
    .system_mode_in(system_mode_in),
    .external_unit_present_bit_in(external_unit_present_bit_in),
    .priv_trap_out(priv_trap),
    .ext_trap_out(ext_trap),
    .ext_go_out(ext_go)
  );

  // command acceptance
  assign cmd_ready_out = state_r == S_IDLE;
  wire logic go = ce_in && cmd_ready_out && cmd_valid_in;
  wire logic trap = priv_trap || ext_trap;
  wire logic seq_cmd = cmd_in.kind inside {K_LD, K_CP, K_CPS, K_TR,
    K_TRT, K_BIN, K_BOUT, K_IOIN, K_IOOUT};
  wire logic seq_go = go && !trap && !ext_go && seq_cmd;
  wire logic [15:0] port_sel = (cmd_in.special || !cmd_in.port_reg) ?
    cmd_in.imm_port : opr_in.port;

  // kind decode of the running sequence
  wire logic k_ld = cmd_r.kind == K_LD;
  wire logic k_cp = cmd_r.kind == K_CP;
  wire logic k_cps = cmd_r.kind == K_CPS;
  wire logic k_tr = cmd_r.kind == K_TR;
  wire logic k_trt = cmd_r.kind == K_TRT;
  wire logic k_bin = cmd_r.kind == K_BIN;
  wire logic k_bout = cmd_r.kind == K_BOUT;
  wire logic k_in = cmd_r.kind == K_IOIN;
  wire logic k_out = cmd_r.kind == K_IOOUT;
  wire logic single_io = k_in || k_out;
  wire logic is_byte = cmd_r.size == SZ_B || k_tr || k_trt;
  wire logic [15:0] delta = is_byte ? BYTE_STEP : WORD_STEP;

  // bus access of the current step
  wire logic [1:0] last_idx = k_tr ? 2'h2 :
    (k_cp || single_io) ? 2'h0 : 2'h1;
  wire logic acc_last = step_r == last_idx;
  wire logic acc_wr = acc_last && (k_ld || k_tr || k_bin || k_bout || k_out);
  wire logic acc_port = single_io || (k_bin && step_r == 2'h0) ||
    (k_bout && step_r == 2'h1);
  wire logic acc_tbl = (k_tr || k_trt) && step_r == 2'h1;
  wire logic use_src = step_r == 2'h0 &&
    (k_ld || k_cp || k_cps || k_trt || k_bout);
  wire logic [31:0] tbl_base = k_tr ? src_r : dst_r;
  wire logic [31:0] mem_ptr = acc_tbl ? tbl_base : use_src ? src_r : dst_r;
  wire logic [15:0] addr_lo = acc_port ? port_r :
    acc_tbl ? tbl_base[15:0] + {8'h00, tmp_r[7:0]} :
    mem_ptr[15:0];
  wire logic [15:0] addr_hi = (acc_port || !cmd_r.seg) ? 16'h0000 :
    mem_ptr[31:16];
  wire logic [3:0] status = acc_port ?
    (cmd_r.special ? ST_SPC_IO : ST_STD_IO) : ST_MEM;
  wire logic hi_lane = acc_port ? cmd_r.special : !addr_lo[0];
  wire logic [7:0] rd_byte = hi_lane ? bus_rdata_in[15:8] : bus_rdata_in[7:0];
  wire logic [15:0] rd_val = is_byte ? {8'h00, rd_byte} : bus_rdata_in;
  wire logic [15:0] wsrc = k_out ? data_r[15:0] : tmp_r;
  wire logic [15:0] wdata = !is_byte ? wsrc :
    hi_lane ? {wsrc[7:0], 8'h00} : {8'h00, wsrc[7:0]};
  wire logic ack = ce_in && bus_req_out && bus_ack_in;

  assign bus_req_out = state_r == S_BUS;
  assign bus_out = bus_req_out ?
    {addr_hi, addr_lo, acc_wr, is_byte, wdata, status} :
    {32'h0000_0000, 1'b0, 1'b0, 16'h0000, ST_IDLE};

  // compare and test of the final read
  wire logic [15:0] cmp_a = k_cp ? data_r[15:0] : tmp_r;
  wire logic [15:0] a_m = is_byte ? {8'h00, cmp_a[7:0]} : cmp_a;
  wire logic [15:0] b_m = rd_val;
  wire logic [15:0] diff = a_m - b_m;
  wire logic met = (a_m == b_m) == cmd_r.cc_eq;
  wire logic hit_now = (k_cp || k_cps) ? met :
    k_trt ? rd_val[7:0] != 8'h00 : 1'b0;

  // end of iteration
  wire logic [15:0] cnt_nxt = cnt_r - 16'h0001;
  wire logic zero_nxt = cnt_nxt == 16'h0000;
  wire logic stop = single_io || zero_nxt || !cmd_r.rpt || hit_r;
  wire logic step_src = k_ld || k_cp || k_cps || k_trt || k_bout;
  wire logic step_dst = k_ld || k_cps || k_tr || k_bin;
  wire logic in_next = ce_in && state_r == S_NEXT;
  wire logic pace_done = itc_r >= ITER_MIN_CYC - 4'h1;

  // flags after acceptance
  wire logic [3:0] f4 = {flags_in.c, flags_in.z, flags_in.s, flags_in.pv};
  wire logic [3:0] fop = cmd_in.flop == FO_SET ? f4 | cmd_in.flag_mask :
    cmd_in.flop == FO_CLR ? f4 & ~cmd_in.flag_mask :
    f4 ^ cmd_in.flag_mask;

  always_comb begin
    acc_flags = flags_in;
    if (!trap && !ext_go) begin
      case (cmd_in.kind)
        K_SHIFT, K_ROT:
          {acc_flags.c, acc_flags.z, acc_flags.s, acc_flags.pv} = sh_czsv;
        K_FLAG:
          {acc_flags.c, acc_flags.z, acc_flags.s, acc_flags.pv} = fop;
        K_CTLB: acc_flags = flags_s'(opr_in.data[7:2]);
        default: acc_flags = flags_in;
      endcase
    end
  end

  // flags at the end of a block iteration; d and h never move
  always_comb begin
    blk_flags = flags_out;
    blk_flags.pv = zero_nxt;
    if (k_cp || k_cps) begin
      blk_flags.z = hit_r;
      blk_flags.c = cmpc_r;
      blk_flags.s = cmps_r;
    end else if (k_trt) begin
      blk_flags.z = hit_r;
    end else if (k_bin || k_bout) begin
      blk_flags.z = zero_nxt;
    end
  end

  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    case (state_r)
      S_IDLE: begin
        step_nxt = 2'h0;
        if (seq_go) state_nxt = S_BUS;
      end
      S_BUS: begin
        if (bus_ack_in && acc_last) state_nxt = S_NEXT;
        else if (bus_ack_in) step_nxt = step_r + 2'h1;
      end
      S_NEXT: begin
        step_nxt = 2'h0;
        state_nxt = (stop || irq_pending_in) ? S_IDLE : S_PACE;
      end
      S_PACE: begin
        if (pace_done) state_nxt = S_BUS;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= S_IDLE;
      step_r <= 2'h0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      step_r <= step_nxt;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      itc_r <= 4'h0;
    end else if (ce_in) begin
      if (seq_go || (state_r == S_PACE && pace_done)) itc_r <= 4'h0;
      else if (itc_r != ITC_SAT) itc_r <= itc_r + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_r <= '0;
      data_r <= 32'h0000_0000;
      port_r <= 16'h0000;
    end else if (seq_go) begin
      cmd_r <= cmd_in;
      data_r <= opr_in.data;
      port_r <= port_sel;
    end
  end

  // pointers and counter: only the low half steps; port stays put
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      src_r <= PTR_RST;
      dst_r <= PTR_RST;
      cnt_r <= CNT_RST;
    end else if (seq_go) begin
      src_r <= opr_in.src;
      dst_r <= opr_in.dst;
      cnt_r <= opr_in.cnt;
    end else if (in_next && !single_io) begin
      cnt_r <= cnt_nxt;
      if (step_src) src_r <= step_ptr(src_r, delta, cmd_r.down);
      if (step_dst) dst_r <= step_ptr(dst_r, delta, cmd_r.down);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tmp_r <= 16'h0000;
      hit_r <= 1'b0;
      cmpc_r <= 1'b0;
      cmps_r <= 1'b0;
    end else if (ack) begin
      tmp_r <= rd_val;
      if (acc_last) begin
        hit_r <= hit_now;
        cmpc_r <= a_m < b_m;
        cmps_r <= is_byte ? diff[7] : diff[15];
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      flags_out <= FLAGS_RST;
    end else if (go) begin
      flags_out <= acc_flags;
    end else if (in_next && !single_io) begin
      flags_out <= blk_flags;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      result_out <= 32'h0000_0000;
      save_pc_out <= 32'h0000_0000;
      ext_amode_out <= AM_R;
    end else if (go && !trap && cmd_in.kind inside {K_SHIFT, K_ROT}) begin
      result_out <= sh_res;
    end else if (go && ext_go) begin
      ext_amode_out <= cmd_in.amode;
    end else if (ack && acc_last && (k_in || k_trt)) begin
      result_out <= {16'h0000, rd_val};
    end else if (in_next && !stop && irq_pending_in) begin
      save_pc_out <= cmd_r.pc;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
      suspend_out <= 1'b0;
      trap_priv_out <= 1'b0;
      trap_ext_out <= 1'b0;
      ext_start_out <= 1'b0;
      ctrl_exec_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= (go && !trap && !seq_cmd) ||
        (state_r == S_NEXT && stop);
      suspend_out <= state_r == S_NEXT && !stop && irq_pending_in;
      trap_priv_out <= go && priv_trap;
      trap_ext_out <= go && ext_trap;
      ext_start_out <= go && ext_go;
      ctrl_exec_out <= go && !trap && cmd_in.kind == K_CTRL;
    end
  end

  assign src_out = src_r;
  assign dst_out = dst_r;
  assign cnt_out = cnt_r;

  // iteration spacing watch, counted between rises of the bus request
  logic [3:0] gap_r;
  logic req_q_r;
  wire logic req_rise = bus_req_out && !req_q_r;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      gap_r <= 4'h0;
      req_q_r <= 1'b0;
    end else if (ce_in) begin
      req_q_r <= bus_req_out;
      gap_r <= req_rise ? 4'h1 :
        (gap_r == ITC_SAT ? gap_r : gap_r + 4'h1);
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_iter_end;
    in_next && !single_io;
  endsequence
  sequence s_iter_go_on;
    in_next && !stop && !irq_pending_in;
  endsequence

  a_cnt_step: assert property (s_iter_end |=>
    cnt_r == $past(cnt_r) - 16'h0001) else $error("counter not stepped");
  a_pv_zero: assert property (s_iter_end and cnt_r == 16'h0001 |=>
    flags_out.pv) else $error("pv not set at zero count");
  a_dh_keep: assert property (s_iter_end |=>
    flags_out.d == $past(flags_out.d) && flags_out.h == $past(flags_out.h))
    else $error("d or h changed by block op");
  a_seg_high: assert property (s_iter_end |=>
    src_r[31:16] == $past(src_r[31:16]) &&
    dst_r[31:16] == $past(dst_r[31:16])) else $error("pointer high moved");
  a_iter_gap: assert property (req_rise &&
    $past(state_r) == S_PACE |-> gap_r >= ITER_MIN_CYC)
    else $error("iteration shorter than nine cycles");
  a_iter_next: assert property (s_iter_go_on |=> state_r == S_PACE
    ##[1:8] state_r == S_BUS)
    else $error("next iteration not started in time");
  a_suspend_pc: assert property (in_next && !stop && irq_pending_in
    |=> suspend_out && !done_out && save_pc_out == $past(cmd_r.pc))
    else $error("suspend did not save own address");
  a_std_lane: assert property (bus_req_out && bus_out.bsel &&
    bus_out.status == ST_STD_IO && bus_out.wr |-> bus_out.wdata[15:8] == 8'h00)
    else $error("standard byte not on low lane");
  a_spc_lane: assert property (bus_req_out && bus_out.bsel &&
    bus_out.status == ST_SPC_IO && bus_out.wr |-> bus_out.wdata[7:0] == 8'h00)
    else $error("special byte not on high lane");
  a_io_priv: assert property (go && !system_mode_in &&
    !ext_go && !ext_trap &&
    cmd_in.kind inside {K_BIN, K_BOUT, K_IOIN, K_IOOUT} |=>
    trap_priv_out && state_r == S_IDLE) else $error("i/o ran in normal mode");
  a_flag_free: assert property (go && cmd_in.kind == K_FLAG &&
    !ext_go && !ext_trap |=> !trap_priv_out && done_out)
    else $error("flag op trapped");
  a_ext_trap: assert property (go && ext_trap |=>
    trap_ext_out && !ext_start_out && !done_out)
    else $error("extended op not trapped");
endmodule

// [rtl/exec_pkg.sv]
// Function
// - arithmetic and logical shifts both ways on 8, 16, 32 bits, any amount; a 32-bit logical right shift fills with bit 31.
// - shift amount comes from the instruction field or from a register.
// - rotate byte or word left or right by one or two, optionally through carry.
// - block move, search and compare cover byte or word blocks to 64K; translate covers byte blocks only.
// - byte translate replaces each byte with the table entry it indexes.
// - translate-and-test skips bytes with zero entries, stops on a marked one.
// - blocks step either way; repeat runs to zero, single steps once.
// - parity/overflow set when the counter reaches zero; repeat forms end set unless a compare or translate-and-test stops early.
// - block ops keep decimal-adjust and half-carry; carry and sign except compares.
// - segmented pointers are pairs and only their low half steps.
// - repeat forms stop between iterations, save own address, resume identically.
// - each repeat iteration after the first takes at least 9 cycles; any bus waits beyond that add to it.
// - standard and special I/O spaces with 16-bit ports and own status codes.
// - standard byte I/O uses the low byte lane and odd ports.
// - special byte I/O uses the high byte lane and even ports.
// - standard port from instruction or register; special port from instruction only.
// - block I/O keeps the port fixed, steps memory, and is interruptible.
// - every I/O instruction runs only in system mode.
// - single I/O keeps flags; block I/O sets zero and parity/overflow.
// - control ops privileged except idle, flag ops and control byte load.
// - opcodes 0e, 0f, 4e, 4f, 8e, 8f go to the external coprocessor.
// - extended opcode runs when the unit-present bit is set, else traps.
// - a privileged op in normal mode traps instead of executing.
// - block compares set zero when the requested condition is met.
package exec_pkg;
  typedef enum logic [3:0] {K_SHIFT, K_ROT, K_LD, K_CP, K_CPS, K_TR, K_TRT,
    K_BIN, K_BOUT, K_IOIN, K_IOOUT, K_FLAG, K_CTLB, K_IDLE, K_CTRL,
    K_EXT} kind_e;
  typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} size_e;
  typedef enum logic [2:0] {SH_SLA, SH_SLL, SH_SRA, SH_SRL, SH_RL, SH_RLC,
    SH_RR, SH_RRC} shop_e;
  typedef enum logic [2:0] {AM_R, AM_PTR, AM_DA, AM_IM, AM_X} amode_e;
  typedef enum logic [1:0] {FO_SET, FO_CLR, FO_INV} flop_e;
  typedef enum logic [3:0] {S_IDLE = 4'b0001, S_BUS = 4'b0010,
    S_NEXT = 4'b0100, S_PACE = 4'b1000} state_e;
  typedef struct packed {logic c, z, s, pv, d, h;} flags_s;
  typedef struct packed {
    logic [7:0] opcode;
    kind_e kind;
    size_e size;
    shop_e shop;
    logic dyn_amt;
    logic [5:0] imm_amt;
    logic two;
    logic down;
    logic rpt;
    logic seg;
    logic special;
    logic port_reg;
    logic [15:0] imm_port;
    logic cc_eq;
    flop_e flop;
    logic [3:0] flag_mask;
    amode_e amode;
    logic [31:0] pc;
  } cmd_s;
  typedef struct packed {
    logic [31:0] data;
    logic [15:0] amt;
    logic [15:0] port;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] cnt;
  } opr_s;
  typedef struct packed {
    logic [31:0] addr;
    logic wr;
    logic bsel;
    logic [15:0] wdata;
    logic [3:0] status;
  } bus_s;
  localparam logic [3:0] ST_IDLE = 4'h0;
  localparam logic [3:0] ST_MEM = 4'h8;
  localparam logic [3:0] ST_STD_IO = 4'h2;
  localparam logic [3:0] ST_SPC_IO = 4'h3;
  localparam logic [3:0] ITER_MIN_CYC = 4'h9;
  localparam logic [3:0] ITC_SAT = 4'hf;
  localparam logic [4:0] EXT_OP_PAT = 5'h07;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [31:0] BYTE_MASK = 32'h0000_00ff;
  localparam logic [31:0] WORD_MASK = 32'h0000_ffff;
  localparam logic [31:0] LONG_MASK = 32'hffff_ffff;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam flags_s FLAGS_RST = 6'h00;
endpackage

// [rtl/shift_unit.sv]
`timescale 1ns/100ps
module shift_unit (
  input wire logic [31:0] val_in,
  input exec_pkg::size_e size_in,
  input exec_pkg::shop_e shop_in,
  input wire logic dyn_in,
  input wire logic [5:0] imm_amt_in,
  input wire logic [15:0] reg_amt_in,
  input wire logic two_in,
  input wire logic cin_in,
  output logic [31:0] res_out,
  output logic [3:0] czsv_out
);
  import exec_pkg::*;

  function automatic logic msb(input logic [31:0] x, input size_e sz);
    msb = sz == SZ_B ? x[7] : sz == SZ_W ? x[15] : x[31];
  endfunction

  // one rotate step; result carries {carry, value}
  function automatic logic [32:0] rot1(input logic [32:0] cv,
    input logic bop, input logic left, input logic thru);
    logic [31:0] v;
    logic top;
    logic fill;
    v = cv[31:0];
    top = bop ? v[7] : v[15];
    if (left) begin
      fill = thru ? cv[32] : top;
      rot1 = {top, v[30:0], fill};
    end else begin
      fill = thru ? cv[32] : v[0];
      v = {1'b0, v[31:1]};
      if (bop) v[7] = fill;
      else v[15] = fill;
      rot1 = {cv[0], v};
    end
  endfunction

  wire logic is_rot = shop_in inside {SH_RL, SH_RLC, SH_RR, SH_RRC};
  wire logic thru = shop_in == SH_RLC || shop_in == SH_RRC;
  wire logic rleft = shop_in == SH_RL || shop_in == SH_RLC;
  wire logic arith = shop_in == SH_SLA || shop_in == SH_SRA;
  wire logic neg = dyn_in && reg_amt_in[15];
  wire logic right = dyn_in ? neg : shop_in inside {SH_SRA, SH_SRL};
  wire logic [15:0] mag = neg ? 16'h0000 - reg_amt_in : reg_amt_in;
  wire logic [5:0] n = dyn_in ? mag[5:0] : imm_amt_in;
  wire logic [31:0] mask = size_in == SZ_B ? BYTE_MASK :
    size_in == SZ_W ? WORD_MASK : LONG_MASK;
  wire logic [31:0] v = val_in & mask;
  wire logic [31:0] ext = (arith && msb(v, size_in)) ? v | ~mask : v;
  wire logic [63:0] lsh = {32'h0000_0000, v} << n;
  wire logic [63:0] rsh = 64'($signed({ext, 32'h0000_0000}) >>> n);
  wire logic bop = size_in == SZ_B;
  wire logic [32:0] r1 = rot1({cin_in, v}, bop, rleft, thru);
  wire logic [32:0] r2 = rot1(r1, bop, rleft, thru);
  wire logic [32:0] rr = two_in ? r2 : r1;
  wire logic lc = bop ? lsh[8] : size_in == SZ_W ? lsh[16] : lsh[32];
  wire logic [31:0] res = (is_rot ? rr[31:0] :
    right ? rsh[63:32] : lsh[31:0]) & mask;
  wire logic c = is_rot ? rr[32] : n == 6'h00 ? cin_in :
    right ? rsh[31] : lc;
  wire logic vf = !is_rot && !right && arith &&
    (msb(res, size_in) != msb(v, size_in));

  assign res_out = res;
  assign czsv_out = {c, res == 32'h0000_0000, msb(res, size_in), vf};
endmodule

// [rtl/op_screen.sv]
`timescale 1ns/100ps
module op_screen (
  input wire logic [7:0] opcode_in,
  input exec_pkg::kind_e kind_in,
  input wire logic system_mode_in,
  input wire logic external_unit_present_bit_in,
  output logic priv_trap_out,
  output logic ext_trap_out,
  output logic ext_go_out
);
  import exec_pkg::*;

  function automatic logic is_ext_op(input logic [7:0] op);
    is_ext_op = op[7:6] != 2'h3 && op[5:1] == EXT_OP_PAT;
  endfunction

  wire logic ext = is_ext_op(opcode_in);
  wire logic priv = !ext && kind_in inside {K_BIN, K_BOUT, K_IOIN,
    K_IOOUT, K_CTRL};

  assign priv_trap_out = priv && !system_mode_in;
  assign ext_trap_out = ext && !external_unit_present_bit_in;
  assign ext_go_out = ext && external_unit_present_bit_in;
endmodule

// [tb/bus_model.sv]
`timescale 1ns/100ps
module bus_model (
  input wire logic clk_sys_in,
  input wire logic req_in,
  input exec_pkg::bus_s bus_in,
  input wire logic slow_in,
  output logic ack_out,
  output logic [15:0] rdata_out
);
  import exec_pkg::*;
  logic [7:0] mem [0:255];
  logic [1:0] wait_r = 2'h0;
  logic [15:0] last_r = 16'h0;
  logic [15:0] pat;
  logic [7:0] a;
  assign a = bus_in.addr[7:0];
  assign pat = bus_in.addr[15:0] ^ 16'ha5c3;
  assign ack_out = req_in && (!slow_in || wait_r == 2'h2);
  // undriven lanes never repeat the last value
  always_comb begin
    if (!req_in)
      rdata_out = ~last_r;
    else if (bus_in.status == ST_MEM)
      rdata_out = {mem[a & 8'hfe], mem[a | 8'h01]};
    else if (bus_in.status == ST_SPC_IO)
      rdata_out = {pat[15:8], ~last_r[7:0]};
    else
      rdata_out = {~last_r[15:8], pat[7:0]};
  end
  always @(posedge clk_sys_in) begin
    last_r <= rdata_out;
    wait_r <= (ack_out || !req_in) ? 2'h0 : wait_r + 2'h1;
    if (ack_out && bus_in.wr && bus_in.status == ST_MEM) begin
      if (!bus_in.bsel || !a[0])
        mem[a & 8'hfe] <= bus_in.wdata[15:8];
      if (!bus_in.bsel || a[0])
        mem[a | 8'h01] <= bus_in.wdata[7:0];
    end
  end
endmodule

// [tb/test_exec_core.sv]
`timescale 1ns/100ps
module test_exec_core;
  import exec_pkg::*;
  logic clk_sys_in = 0, rst_in = 1, valid = 0, sysm = 0, pres = 0;
  logic irq = 0, slow = 0, req, ack, done, susp, tp, te, es, cx;
  logic [15:0] rdata, cnt, d, p;
  logic [31:0] res, spc, src, dst;
  cmd_s cmd = '0;
  opr_s opr = '0;
  flags_s fl = '0, flo;
  bus_s bus;
  amode_e am;
  int err_count = 0, cmp_count = 0, a, e;
  logic [7:0] pat [0:3];
  kind_e kt [0:4] = '{K_IOIN, K_CTRL, K_FLAG, K_IDLE, K_CTLB};
  always #50 clk_sys_in = ~clk_sys_in;
  exec_core u_exec_core (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .ce_in(1'b1), .cmd_valid_in(valid), .cmd_in(cmd), .opr_in(opr),
    .flags_in(fl), .system_mode_in(sysm),
    .external_unit_present_bit_in(pres), .irq_pending_in(irq),
    .bus_ack_in(ack), .bus_rdata_in(rdata), .cmd_ready_out(),
    .bus_req_out(req), .bus_out(bus), .done_out(done),
    .suspend_out(susp), .trap_priv_out(tp), .trap_ext_out(te),
    .ext_start_out(es), .ctrl_exec_out(cx), .ext_amode_out(am),
    .flags_out(flo), .result_out(res), .save_pc_out(spc),
    .src_out(src), .dst_out(dst), .cnt_out(cnt));
  bus_model u_bus_model (.clk_sys_in(clk_sys_in), .req_in(req),
    .bus_in(bus), .slow_in(slow), .ack_out(ack), .rdata_out(rdata));
  task automatic results();
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %0t: got %h want %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic run();
    int n;
    n = 0;
    @(negedge clk_sys_in);
    valid = 1;
    @(negedge clk_sys_in);
    valid = 0;
    while ((done | susp | tp | te | es) !== 1'b1 && n < 300) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n == 300) begin
      $display("unexpected %0t: no completion", $time);
      err_count++;
      results();
    end
  endtask
  initial begin
    void'($urandom(32'h2825e3d3));
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_in = 0;
    sysm = 1;
    for (int i = 0; i < 8; i++) begin
      a = $urandom % 17;
      d = 16'($urandom);
      cmd = '0;
      cmd.kind = K_SHIFT;
      cmd.size = SZ_W;
      cmd.dyn_amt = i[0];
      cmd.imm_amt = 6'(a);
      cmd.shop = (i[0] || i[1]) ? (i[2] ? SH_SLA : SH_SLL) :
        (i[2] ? SH_SRA : SH_SRL);
      opr.amt = i[1] ? 16'(a) : -16'(a);
      opr.data = {16'h0, d};
      run();
      e = i[1] ? int'(d) << a : i[2] ? int'($signed(d)) >>> a : d >> a;
      check(32'(res[15:0]), 32'(e[15:0]));
    end
    for (int i = 0; i < 6; i++) begin
      cmd = '0;
      cmd.kind = K_EXT;
      cmd.opcode = 8'h0e + 8'h40 * 8'(i / 2) + 8'(i % 2);
      cmd.amode = amode_e'(i % 5);
      pres = i[0];
      run();
      check(32'({te, es}), 32'({!pres, pres}));
      if (pres) check(32'(am), 32'(i % 5));
    end
    for (int i = 0; i < 10; i++) begin
      cmd = '0;
      cmd.kind = kt[i % 5];
      sysm = i >= 5;
      run();
      e = i < 2 ? 4 : i == 6 ? 3 : 2;
      check(32'({tp, done, cx}), 32'(e));
    end
    for (int s = 0; s < 2; s++) begin
      cmd = '0;
      cmd.kind = K_IOIN;
      cmd.special = s[0];
      cmd.imm_port = s ? 16'h0010 : 16'h0011;
      fl = 6'($urandom);
      p = cmd.imm_port ^ 16'ha5c3;
      run();
      e = int'(s ? p[15:8] : p[7:0]);
      check(32'(res[7:0]), 32'(e));
      check(32'(flo), 32'(fl));
    end
    for (int k = 0; k < 4; k++) begin
      pat[k] = 8'($urandom);
      u_bus_model.mem[8'h10 + k] = pat[k];
    end
    cmd = '0;
    cmd.kind = K_LD;
    cmd.rpt = 1;
    cmd.pc = 32'h0000_1234;
    opr = '{32'h0, 16'h0, 16'h0, 32'h10, 32'h41, 16'h3};
    fl = 6'b100011;
    irq = 1;
    slow = 1;
    run();
    check(32'(susp), 32'h1);
    check(spc, 32'h1234);
    check(src, 32'h11);
    check(dst, 32'h42);
    check(32'(cnt), 32'h2);
    irq = 0;
    opr = '{32'h0, 16'h0, 16'h0, 32'h11, 32'h42, 16'h2};
    run();
    check(32'(done), 32'h1);
    check(src, 32'h13);
    check(dst, 32'h44);
    check(32'(cnt), 32'h0);
    check(32'({flo.pv, flo.c, flo.d, flo.h}), 32'hf);
    for (int k = 0; k < 3; k++)
      check(32'(u_bus_model.mem[8'h41 + k]), 32'(pat[k]));
    results();
  end
endmodule
